// [common/gcd_defines.vh]
// constants of the gated clock divider control block
// Operation
// - gate pin high lets divided output run freely at configured rate
// - gate low holds divided output low, after its falling edge if high
// - while gated off oscillator and prescaler run, divide counter held reset
// - first output edge on first master rising edge after synchronised gate release
// - reference output ignores gate pin while its disable bit is 0
// - pin role bit: 1 makes dual pin power-down, 0 source select
// - power-down gates divided, then reference output, then oscillator
// - in power-down both clock outputs high impedance, buffers off
// - select mode: dual pin high picks internal, low picks external
// - reference disable bit 1 keeps reference output off, high impedance
// - reference output is the reference selection mux output
// - programmed words kept non-volatile, reloaded at operating power-up
// - configuration is two nine-bit words: mode word and divider word
// - shared clock pin is output except in programming mode and power-down
// - delivered configuration gives half the maximum frequency
// - divisor equals programmed value plus two, 2 to 513
// - prescale ratio 0 divides by 4, 1 by 2; bypass bit skips
// - divider bypass sends master clock straight to divided output
// - power-down role: source bit 1 external, 0 internal
`ifndef GCD_DEFINES_VH
`define GCD_DEFINES_VH
`define GCD_WORD_W        9
`define GCD_BIT_REF_OFF   5
`define GCD_BIT_PIN_ROLE  4
`define GCD_BIT_PRE_RATIO 3
`define GCD_BIT_PRE_BYP   2
`define GCD_BIT_CNT_BYP   1
`define GCD_BIT_SRC_EXT   0
`define GCD_MODE_DEFAULT  9'h01a
`define GCD_DIV_DEFAULT   9'h000
`define GCD_DIV_OFFSET    10'h002
`define GCD_ST_RUN        4'h1
`define GCD_ST_PD_DIV     4'h2
`define GCD_ST_PD_REF     4'h4
`define GCD_ST_SLEEP      4'h8
`endif

// [design/gcd_top.v]
// gated clock divider control: source mux, prescaler, divider, gating
`timescale 1ns/1ps
`default_nettype none
`include "gcd_defines.vh"
module gcd_top (
  input  wire       CLK_I,
  input  wire       RST_N_I,
  input  wire       OUT_GATE_I,
  input  wire       SLEEP_OR_SOURCE_PIN_I,
  input  wire       REF_CLOCK_IN_PIN_I,
  input  wire       PROG_MODE_I,
  input  wire       PROG_WR_I,
  input  wire [8:0] PROG_MODE_WORD_I,
  input  wire [8:0] PROG_DIV_WORD_I,
  output wire       DIV_CLK_O,
  output wire       DIV_CLK_OE_O,
  output wire       REFERENCE_CLOCK_PIN_O,
  output wire       REFERENCE_CLOCK_PIN_OE_O,
  output wire [8:0] NV_MODE_WORD_O,
  output wire [8:0] NV_DIV_WORD_O
);
  // one-hot power-down sequencer states
  localparam [3:0] st_run    = `GCD_ST_RUN;
  localparam [3:0] st_pd_div = `GCD_ST_PD_DIV;
  localparam [3:0] st_pd_ref = `GCD_ST_PD_REF;
  localparam [3:0] st_sleep  = `GCD_ST_SLEEP;
  reg        rst_s1_r;
  reg        rst_s2_r;
  wire       rst_n = rst_s2_r;
  // pin synchronisers
  reg        gate_s1_r;
  reg        gate_s2_r;
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        ext_s1_r;
  reg        ext_s2_r;
  // non-volatile store: power-up content is the delivered setting
  reg  [8:0] nv_mode_r = `GCD_MODE_DEFAULT;
  reg  [8:0] nv_div_r  = `GCD_DIV_DEFAULT;
  reg  [8:0] mode_r;
  reg  [8:0] div_word_r;
  reg  [8:0] nv_mode_o_r;
  reg  [8:0] nv_div_o_r;
  reg        booted_r;
  reg        prog_r;
  reg  [3:0] st_r;
  reg        osc_r;
  reg        osc_prev_r;
  reg        src_ext_r;
  reg        mst_prev_r;
  reg  [1:0] pre_cnt_r;
  reg  [9:0] cnt_r;
  reg        div_run_r;
  reg        div_o_r;
  reg        div_oe_r;
  reg        ref_run_r;
  reg        ref_o_r;
  reg        ref_oe_r;
  wire       role_pd   = mode_r[`GCD_BIT_PIN_ROLE];
  wire       pd_req    = role_pd & ~pin_s2_r;
  wire       sleeping  = (st_r == st_sleep);
  wire       src_want;
  wire       osc_tick;
  wire       int_lvl;
  wire       src_lvl;
  wire       want_lvl;
  wire       mst_lvl;
  wire       mst_tick;
  wire       cnt_byp   = mode_r[`GCD_BIT_CNT_BYP];
  wire [9:0] divisor   = {1'b0, div_word_r} + `GCD_DIV_OFFSET;
  wire [9:0] half      = {1'b0, divisor[9:1]};
  wire       gate_on   = gate_s2_r & (st_r == st_run) & ~prog_r;
  wire       rise_next = cnt_byp ? mst_lvl : (mst_tick & (cnt_r == 10'h000));

  // select mode follows the pin, power-down role follows the bit
  assign src_want = role_pd ? mode_r[`GCD_BIT_SRC_EXT]
                            : ~pin_s2_r;
  assign osc_tick = osc_r & ~osc_prev_r;
  // prescaler serves the internal oscillator only
  assign int_lvl  = mode_r[`GCD_BIT_PRE_BYP]   ? osc_r        :
                    mode_r[`GCD_BIT_PRE_RATIO] ? pre_cnt_r[0] :
                                                 pre_cnt_r[1];
  // the reference mux output is the master clock
  assign src_lvl  = src_ext_r ? ext_s2_r : int_lvl;
  assign want_lvl = src_want ? ext_s2_r : int_lvl;
  assign mst_lvl  = src_lvl;
  assign mst_tick = mst_lvl & ~mst_prev_r;

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
    end else begin
      gate_s1_r <= OUT_GATE_I;
      gate_s2_r <= gate_s1_r;
      pin_s1_r  <= SLEEP_OR_SOURCE_PIN_I;
      pin_s2_r  <= pin_s1_r;
      ext_s1_r  <= REF_CLOCK_IN_PIN_I;
      ext_s2_r  <= ext_s1_r;
    end
  end

  // store has no reset so its content survives power cycles
  always @(posedge CLK_I) begin
    if (prog_r && PROG_WR_I) begin
      nv_mode_r <= PROG_MODE_WORD_I;
      nv_div_r  <= PROG_DIV_WORD_I;
    end
  end

  // working words load once after power-up; never changed on the fly
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      booted_r    <= 1'b0;
      prog_r      <= 1'b0;
      mode_r      <= 9'h000;
      div_word_r  <= 9'h000;
      nv_mode_o_r <= 9'h000;
      nv_div_o_r  <= 9'h000;
    end else begin
      nv_mode_o_r <= nv_mode_r;
      nv_div_o_r  <= nv_div_r;
      if (!booted_r) begin
        booted_r <= 1'b1;
        prog_r   <= PROG_MODE_I;
        if (!PROG_MODE_I) begin
          mode_r     <= nv_mode_r;
          div_word_r <= nv_div_r;
        end
      end
    end
  end

  // power-down sequencer
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= st_run;
    end else begin
      case (st_r)
        st_run:    if (pd_req) st_r <= st_pd_div;
        st_pd_div: if (!div_run_r) st_r <= st_pd_ref;
        st_pd_ref: if (!ref_run_r) st_r <= st_sleep;
        st_sleep:  if (!pd_req) st_r <= st_run;
        default:   st_r <= st_run;
      endcase
    end
  end

  // oscillator, source mux and prescaler
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      osc_r      <= 1'b0;
      src_ext_r  <= 1'b0;
      osc_prev_r <= 1'b0;
      pre_cnt_r  <= 2'h0;
      mst_prev_r <= 1'b0;
    end else begin
      osc_r      <= sleeping ? 1'b0 : ~osc_r;
      // switch only while both sources are low: no runt pulse
      if (!src_lvl && !want_lvl)
        src_ext_r <= src_want;
      osc_prev_r <= osc_r;
      if (osc_tick)
        pre_cnt_r <= pre_cnt_r + 2'h1;
      mst_prev_r <= mst_lvl;
    end
  end

  // divided output with synchronous gating
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      div_run_r <= 1'b0;
      div_o_r   <= 1'b0;
      cnt_r     <= 10'h000;
      div_oe_r  <= 1'b0;
    end else begin
      div_oe_r <= booted_r & ~prog_r & ~sleeping;
      if (!div_run_r) begin
        cnt_r   <= 10'h000;
        div_o_r <= 1'b0;
        // bypass starts only while master is low
        if (gate_on && (!cnt_byp || !mst_lvl))
          div_run_r <= 1'b1;
      end else if (!gate_on && !div_o_r && !rise_next) begin
        div_run_r <= 1'b0;
      end else if (cnt_byp) begin
        div_o_r <= mst_lvl;
      end else if (mst_tick) begin
        cnt_r <= (cnt_r == divisor - 10'h001) ? 10'h000 : cnt_r + 10'h001;
        if (cnt_r == 10'h000)
          div_o_r <= 1'b1;
        else if (cnt_r == half)
          div_o_r <= 1'b0;
      end
    end
  end

  // reference output: mux copy, untouched by the gate pin
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ref_run_r <= 1'b0;
      ref_o_r   <= 1'b0;
      ref_oe_r  <= 1'b0;
    end else begin
      ref_oe_r <= booted_r & ~sleeping
                & ~mode_r[`GCD_BIT_REF_OFF];
      if (st_r == st_run)
        ref_run_r <= 1'b1;
      else if (st_r == st_pd_ref && !src_lvl)
        ref_run_r <= 1'b0;
      ref_o_r <= ref_run_r & src_lvl;
    end
  end

  assign DIV_CLK_O                = div_o_r;
  assign DIV_CLK_OE_O             = div_oe_r;
  assign REFERENCE_CLOCK_PIN_O    = ref_o_r;
  assign REFERENCE_CLOCK_PIN_OE_O = ref_oe_r;
  assign NV_MODE_WORD_O           = nv_mode_o_r;
  assign NV_DIV_WORD_O            = nv_div_o_r;
endmodule // gcd_top
`default_nettype wire

// [tb/gcd_board.sv]
// board-side model: free-running external reference clock source
`timescale 1ns/1ps
`default_nettype none
module gcd_board (
  output logic ref_o
);
  // 16 clock periods, well below the clock/4 sampling limit
  initial begin
    ref_o = 1'b0;
    forever #160 ref_o = ~ref_o;
  end
endmodule // gcd_board
`default_nettype wire

// [tb/gcd_top_properties.sv]
// port-level properties of the clock divider control
`timescale 1ns/1ps
`default_nettype none
module gcd_props (
  input wire       CLK_I,
  input wire       RST_N_I,
  input wire       OUT_GATE_I,
  input wire       SLEEP_OR_SOURCE_PIN_I,
  input wire       PROG_MODE_I,
  input wire       PROG_WR_I,
  input wire [8:0] PROG_MODE_WORD_I,
  input wire       DIV_CLK_O,
  input wire       DIV_CLK_OE_O,
  input wire       REFERENCE_CLOCK_PIN_O,
  input wire       REFERENCE_CLOCK_PIN_OE_O,
  input wire [8:0] NV_MODE_WORD_O
);
  logic [3:0] up_r;
  wire        s = SLEEP_OR_SOURCE_PIN_I;
  // settle time after reset so boot loading is not judged
  wire        ok = (up_r == 4'h8) && !PROG_MODE_I;
  wire        intl = NV_MODE_WORD_O[4] ? !NV_MODE_WORD_O[0] : s;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) up_r <= 4'h0;
    else if (up_r != 4'h8) up_r <= up_r + 4'h1;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence seq_gated;
    (!OUT_GATE_I)[*8] ##1 (!OUT_GATE_I && !DIV_CLK_O)[*2];
  endsequence
  sequence seq_asleep;
    !DIV_CLK_OE_O && !REFERENCE_CLOCK_PIN_OE_O;
  endsequence
  gate_hold_a: assert property (ok throughout seq_gated
    |=> !DIV_CLK_O) else $error("divided clock moved while gated");
  first_rise_a: assert property ($rose(OUT_GATE_I) && ok && intl && s
    |-> ##[2:40] $rose(DIV_CLK_O)) else $error("late first edge");
  ref_run_a: assert property (!OUT_GATE_I && ok && intl && s
    && $past(s, 8) && !NV_MODE_WORD_O[5] |-> REFERENCE_CLOCK_PIN_OE_O
    ##[1:8] REFERENCE_CLOCK_PIN_O != $past(REFERENCE_CLOCK_PIN_O))
    else $error("reference stopped by gate");
  pd_hiz_a: assert property ($fell(s) && ok && NV_MODE_WORD_O[4]
    |-> ##[1:1000] seq_asleep) else $error("no power-down");
  ref_off_a: assert property (ok && NV_MODE_WORD_O[5]
    |-> !REFERENCE_CLOCK_PIN_OE_O) else $error("reference driven");
  prog_out_a: assert property (PROG_MODE_I |-> !DIV_CLK_OE_O)
    else $error("clock driven in programming");
  store_wr_a: assert property (PROG_MODE_I && PROG_WR_I
    && up_r == 4'h8 |-> ##2 NV_MODE_WORD_O == $past(PROG_MODE_WORD_I, 2))
    else $error("word not stored");
  store_hold_a: assert property (up_r == 4'h8 && !PROG_WR_I
    && !$past(PROG_WR_I) |=> $stable(NV_MODE_WORD_O))
    else $error("stored word changed");
endmodule // gcd_props
bind gcd_top gcd_props i_gcd_props (.CLK_I, .RST_N_I, .OUT_GATE_I,
  .SLEEP_OR_SOURCE_PIN_I, .PROG_MODE_I, .PROG_WR_I, .PROG_MODE_WORD_I,
  .DIV_CLK_O, .DIV_CLK_OE_O, .REFERENCE_CLOCK_PIN_O,
  .REFERENCE_CLOCK_PIN_OE_O, .NV_MODE_WORD_O);
`default_nettype wire

// [tb/tb_gcd_top.sv]
// self-checking testbench of the clock divider control
`timescale 1ns/1ps
`default_nettype none
module tb_gcd_top;
  logic       clk = 1'b0, rst_n = 1'b0, gate = 1'b1, pin = 1'b1;
  logic       pm = 1'b0, wr = 1'b0;
  logic [8:0] mw = 9'h000, dw = 9'h000;
  wire        dco, doe, rco, roe, ext;
  wire  [8:0] nvm, nvd;
  int         err_count = 0, checks_done = 0, cyc = 0;
  gcd_top i_gcd_top (.CLK_I(clk), .RST_N_I(rst_n), .OUT_GATE_I(gate),
    .SLEEP_OR_SOURCE_PIN_I(pin), .REF_CLOCK_IN_PIN_I(ext),
    .PROG_MODE_I(pm), .PROG_WR_I(wr), .PROG_MODE_WORD_I(mw),
    .PROG_DIV_WORD_I(dw), .DIV_CLK_O(dco), .DIV_CLK_OE_O(doe),
    .REFERENCE_CLOCK_PIN_O(rco), .REFERENCE_CLOCK_PIN_OE_O(roe),
    .NV_MODE_WORD_O(nvm), .NV_DIV_WORD_O(nvd));
  gcd_board i_gcd_board (.ref_o(ext));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // reset doubles as a power cycle; strap set while held
  task automatic boot(logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    pm <= p;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(negedge clk);
  endtask
  // cycles between two rises, sampled on the quiet edge
  task automatic per(bit r, output logic [15:0] n);
    logic p;
    repeat (2) begin
      n = 16'h0;
      do begin
        p = r ? rco : dco;
        @(negedge clk);
        n++;
      end while (!(p === 1'b0 && (r ? rco : dco) === 1'b1) && n < 16'h400);
    end
  endtask
  task automatic prog(logic [8:0] m, logic [8:0] d);
    boot(1'b1);
    check("prog_oe", 16'h0, doe);
    @(posedge clk);
    mw <= m;
    dw <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (4) @(negedge clk);
    check("nv_mode", m, nvm);
    check("nv_div", d, nvd);
    boot(1'b0);
  endtask
  task automatic t_default();
    logic [15:0] n;
    boot(1'b0);
    check("mode_dflt", 16'h01a, nvm);
    check("div_dflt", 16'h000, nvd);
    per(1'b0, n);
    check("div_per", 16'h4, n);
    $display("t_default done");
  endtask
  task automatic t_gate();
    logic [15:0] n;
    logic        hi;
    @(posedge clk);
    gate <= 1'b0;
    repeat (30) @(negedge clk);
    hi = 1'b0;
    repeat (20) @(negedge clk) hi |= dco;
    check("gated", 16'h0, hi);
    per(1'b1, n);
    check("ref_per", 16'h4, n);
    @(posedge clk);
    gate <= 1'b1;
    per(1'b0, n);
    check("run_per", 16'h4, n);
    $display("t_gate done");
  endtask
  task automatic t_sleep();
    @(posedge clk);
    pin <= 1'b0;
    repeat (60) @(negedge clk);
    check("sleep_doe", 16'h0, doe);
    check("sleep_roe", 16'h0, roe);
    @(posedge clk);
    pin <= 1'b1;
    repeat (60) @(negedge clk);
    check("wake_doe", 16'h1, doe);
    $display("t_sleep done");
  endtask
  task automatic t_select();
    logic [15:0] n;
    prog(9'h000, 9'h001);
    per(1'b0, n);
    check("int_per", 16'h18, n);
    @(posedge clk);
    pin <= 1'b0;
    repeat (200) @(negedge clk);
    per(1'b1, n);
    check("ext_ref", 16'h10, n);
    per(1'b0, n);
    check("ext_per", 16'h30, n);
    @(posedge clk);
    pin <= 1'b1;
    prog(9'h013, 9'h000);
    per(1'b0, n);
    check("pd_ext_per", 16'h10, n);
    per(1'b1, n);
    check("pd_ext_ref", 16'h10, n);
    prog(9'h026, 9'h0ff);
    check("ref_off", 16'h0, roe);
    per(1'b0, n);
    check("byp_per", 16'h2, n);
    $display("t_select done");
  endtask
  initial begin
    t_default();
    t_gate();
    t_sleep();
    t_select();
    end_of_test();
  end
endmodule // tb_gcd_top
`default_nettype wire
